// File: rtl/ccd_timing_regs.vh
// Timing constants for the linear CCD clock generator
`ifndef CCD_TIMING_REGS_VH
`define CCD_TIMING_REGS_VH

// System clock period in ns
`define SYS_PERIOD_NS     4
// Least reset pulse high time in ns
`define RST_MIN_NS        40
`define RST_MIN_CYC       ((`RST_MIN_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
// Reset pulse lasts two master ticks, so each tick needs half of it
`define MIN_DIV           ((`RST_MIN_CYC + 1) / 2)
// Least transfer-gate high time in ns
`define XCK_MIN_NS        40
`define XCK_MIN_CYC       ((`XCK_MIN_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
// Least lead of transfer-gate before transport falls, in ns
`define XCK_LEAD_NS       30
`define XCK_LEAD_CYC      ((`XCK_LEAD_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

// Master tick divider used when the configured one is too small
`define DIV_RESET         8'h06
`define DIV_W             8

// Quadrature phase codes (two-bit Johnson sequence)
`define PH_A              2'b10
`define PH_B              2'b11
`define PH_C              2'b01
`define PH_D              2'b00

// Exposure counter width and least line length in transport periods
`define EXP_W             16
`define MIN_LINE          16'h0051
// Black-level clamp window, transport periods after transfer
`define CLAMP_FIRST       16'h0006
`define CLAMP_LAST        16'h0007
// Black-level sample window, transport periods after transfer
`define SAMPLE_FIRST      16'h004D
`define SAMPLE_LAST       16'h004E

// Pixel index layout, data periods after transfer
`define PIX_W             16
`define ISO_PIX           16'h0004
`define DARK_PRE_FIRST    16'h000C
`define DARK_PRE_LAST     16'h000F
`define DARK_POST_FIRST   16'h009A
`define DARK_POST_LAST    16'h009D

`endif

// File: rtl/exposure_down_counter.v
// Exposure down-counter of transport periods with reload and elapsed count
`timescale 1ns/1ns
module exposure_down_counter (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        clr,
  input  wire        step,
  input  wire [15:0] load_value,
  output wire [15:0] count,
  output wire [15:0] elapsed,
  output wire        terminal
);

  `include "ccd_timing_regs.vh"

  reg  [15:0] count_reg;
  reg  [15:0] count_next;
  reg  [15:0] elapsed_reg;
  reg  [15:0] elapsed_next;
  wire [15:0] load_eff;

  // Never shorter than a whole line readout
  assign load_eff = (load_value < `MIN_LINE) ? `MIN_LINE : load_value;
  assign terminal = (count_reg == 16'h0000);
  assign count    = count_reg;
  assign elapsed  = elapsed_reg;

  always @* begin
    count_next   = count_reg;
    elapsed_next = elapsed_reg;
    if (step) begin
      if (terminal) begin
        count_next   = load_eff - 16'h0001;
        elapsed_next = 16'h0000;
      end else begin
        count_next   = count_reg - 16'h0001;
        elapsed_next = elapsed_reg + 16'h0001;
      end
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg   <= 16'h0000;
      elapsed_reg <= 16'hFFFF;
    end else if (clr) begin
      count_reg   <= 16'h0000;
      elapsed_reg <= 16'hFFFF;
    end else begin
      count_reg   <= count_next;
      elapsed_reg <= elapsed_next;
    end
  end

endmodule

// File: rtl/linear_ccd_clock_timing_gen.v
// Clock and switch timing generator for a linear CCD image sensor
//
// What this block does
// - Reset pulse stays high at least 40 ns in every data period.
// - Reset pulse rises on the same edge as each transport transition, never before.
// - One transport period spans exactly two data periods.
// - Master tick runs at four times the data rate; first divider steps on it.
// - First divider divides by four into quadrature complementary phases.
// - Reset clock is a registered copy of phase A, in phase with it.
// - Transport clock is phase divider output divided by two.
// - Transfer gate rises with transport, falls mid second half-period.
// - Transfer gate high time never below 40 ns.
// - White reference formed by gating transport first half with transfer gate.
// - Down-counter of transport periods sets exposure and gate repetition.
// - Transfer gate and white reference asserted at least 30 ns before transport falls.
// - Dark-reference pixels located four isolation pixels around the data stream.
// - Clamp switch open except during pre-data dark-reference pixels.
// - Clamp switch opens when pre-data dark interval ends, until next clamp.
// - Sample switch closes during post-data dark pixels, apart from clamp.
// - Reset clock pulses once in each transport half cycle.
// - Transfer gate high only while transport clock is high at its start.
// - White reference low while transfer gate and transport are both high.
// - Clamp pulse decoded from exposure counter, four pixels long.
`timescale 1ns/1ns
module linear_ccd_clock_timing_gen (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        run,
  input  wire [7:0]  master_div,
  input  wire [15:0] exposure_count,
  output reg         transport_clock,
  output reg         reset_clock_out,
  output reg         transfer_gate_clock,
  output reg         white_ref_clock,
  output reg         clamp_switch_ctl,
  output reg         sample_switch_ctl,
  output reg         dark_ref_pre,
  output reg         dark_ref_post,
  output reg         line_start,
  output reg         timing_active
);

  `include "ccd_timing_regs.vh"

  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_STOP = 2'b10;

  // Reset release synchroniser
  reg         rst_meta_reg;
  reg         rst_sync_n_reg;

  // Control state
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         active;
  reg         live;

  // Master tick divider
  reg  [7:0]  div_cnt_reg;
  reg  [7:0]  div_cnt_next;
  reg  [7:0]  div_eff_reg;
  wire [7:0]  div_eff;
  wire        master_tick;

  // Quadrature phase divider
  reg  [1:0]  phase_reg;
  reg  [1:0]  phase_next;
  wire        phase_a;
  wire        phase_b;
  wire        phase_c;
  wire        phase_d;
  wire        data_start;
  wire        data_mid;

  // Transport divider and derived clocks
  reg         tck_reg;
  reg         tck_next;
  reg         xck_reg;
  reg         xck_next;
  reg         xck_low_half_reg;
  reg         xck_low_half_next;
  reg         rck_next;
  reg         wr_next;
  wire        tck_rise;

  // Pixel index since last transfer
  reg  [15:0] pix_reg;
  reg  [15:0] pix_next;
  reg         pix_valid_reg;

  // Exposure counter outputs
  wire [15:0] exp_count;
  wire [15:0] exp_elapsed;
  wire        exp_terminal;
  wire        exp_step;
  wire [15:0] elapsed_ahead;

  // Decodes
  reg         clamp_next;
  reg         sample_next;
  reg         pre_next;
  reg         post_next;
  reg         start_next;

  // Two-flop release of the asynchronous reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // Divider ratio is sampled every cycle while idle, and while running only at a data period boundary
  assign div_eff = (master_div < `MIN_DIV) ? `DIV_RESET : master_div;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        // Finish the transport period so no clock is cut short
        if (master_tick && (phase_reg == `PH_D) && !tck_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @* begin
    active = (state_reg != ST_IDLE);
    // Low on the edge that ends a stop, so no clock starts a new half there
    live   = active && (state_next != ST_IDLE);
  end

  // Master tick, four per data period
  assign master_tick = active && (div_cnt_reg == 8'h00);

  always @* begin
    if (!active || master_tick) begin
      div_cnt_next = div_eff_reg - 8'h01;
    end else begin
      div_cnt_next = div_cnt_reg - 8'h01;
    end
  end

  // Johnson sequence gives A, B and their complements C, D
  always @* begin
    phase_next = phase_reg;
    if (master_tick) begin
      case (phase_reg)
        `PH_D:   phase_next = `PH_A;
        `PH_A:   phase_next = `PH_B;
        `PH_B:   phase_next = `PH_C;
        `PH_C:   phase_next = `PH_D;
        default: phase_next = `PH_D;
      endcase
    end
  end

  assign phase_a    = phase_reg[1];
  assign phase_b    = phase_reg[0];
  assign phase_c    = ~phase_reg[1];
  assign phase_d    = ~phase_reg[0];
  assign data_start = master_tick && (phase_reg == `PH_D);
  assign data_mid   = master_tick && (phase_reg == `PH_B);
  assign tck_rise   = data_start && !tck_reg;
  assign exp_step   = tck_rise;
  // Counter value after this edge, so the switches move with the pixel windows
  assign elapsed_ahead = !exp_step    ? exp_elapsed :
                         exp_terminal ? 16'h0000    :
                                        exp_elapsed + 16'h0001;

  exposure_down_counter u_exposure (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .clr        (!rst_sync_n_reg || !active),
    .step       (exp_step),
    .load_value (exposure_count),
    .count      (exp_count),
    .elapsed    (exp_elapsed),
    .terminal   (exp_terminal)
  );

  always @* begin
    // Transport toggles once per data period, two per period
    tck_next = tck_reg;
    if (data_start) begin
      tck_next = ~tck_reg;
    end
    // Reset clock follows phase A on the same edge as transport
    rck_next = phase_a;
    if (master_tick) begin
      rck_next = phase_next[1];
    end
    // Transfer gate starts on a transport rise at terminal count
    xck_next          = xck_reg;
    xck_low_half_next = xck_low_half_reg;
    if (tck_rise && exp_terminal) begin
      xck_next          = 1'b1;
      xck_low_half_next = 1'b0;
    end else if (xck_reg && data_start && tck_reg) begin
      xck_low_half_next = 1'b1;
    end else if (xck_reg && xck_low_half_reg && data_mid) begin
      xck_next          = 1'b0;
      xck_low_half_next = 1'b0;
    end
    // White reference low only while transport first half and gate overlap
    wr_next = ~(tck_next & xck_next);
    // Idle levels also on the edge that completes a stop
    if (!live) begin
      tck_next          = 1'b0;
      rck_next          = 1'b0;
      xck_next          = 1'b0;
      xck_low_half_next = 1'b0;
      wr_next           = 1'b1;
    end
  end

  // Pixel index counts data periods from the transfer
  always @* begin
    pix_next = pix_reg;
    if (tck_rise && exp_terminal) begin
      pix_next = 16'h0000;
    end else if (data_start && pix_reg != 16'hFFFF) begin
      pix_next = pix_reg + 16'h0001;
    end
  end

  always @* begin
    // Dark pixels sit four isolation pixels before and after the data
    pre_next  = live && pix_valid_reg &&
                (pix_next >= `DARK_PRE_FIRST) && (pix_next <= `DARK_PRE_LAST);
    post_next = live && pix_valid_reg &&
                (pix_next >= `DARK_POST_FIRST) && (pix_next <= `DARK_POST_LAST);
    // Switch windows come from the exposure counter, two transport periods each
    clamp_next  = live && (elapsed_ahead >= `CLAMP_FIRST) &&
                  (elapsed_ahead <= `CLAMP_LAST);
    sample_next = live && (elapsed_ahead >= `SAMPLE_FIRST) &&
                  (elapsed_ahead <= `SAMPLE_LAST) && !clamp_next;
    // A line start marks only a transfer that really goes out
    start_next  = live && tck_rise && exp_terminal;
  end

  // Control and divider state, cleared synchronously by the released reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg        <= ST_IDLE;
      div_cnt_reg      <= 8'h00;
      div_eff_reg      <= `DIV_RESET;
      phase_reg        <= `PH_D;
      tck_reg          <= 1'b0;
      xck_reg          <= 1'b0;
      xck_low_half_reg <= 1'b0;
      pix_reg          <= 16'hFFFF;
      pix_valid_reg    <= 1'b0;
    end else if (!rst_sync_n_reg) begin
      state_reg        <= ST_IDLE;
      div_cnt_reg      <= 8'h00;
      div_eff_reg      <= `DIV_RESET;
      phase_reg        <= `PH_D;
      tck_reg          <= 1'b0;
      xck_reg          <= 1'b0;
      xck_low_half_reg <= 1'b0;
      pix_reg          <= 16'hFFFF;
      pix_valid_reg    <= 1'b0;
    end else begin
      state_reg        <= state_next;
      div_cnt_reg      <= div_cnt_next;
      if (!active || data_start) begin
        div_eff_reg <= div_eff;
      end
      phase_reg        <= active ? phase_next : `PH_D;
      tck_reg          <= tck_next;
      xck_reg          <= xck_next;
      xck_low_half_reg <= xck_low_half_next;
      pix_reg          <= active ? pix_next : 16'hFFFF;
      if (!active) begin
        pix_valid_reg <= 1'b0;
      end else if (tck_rise && exp_terminal) begin
        pix_valid_reg <= 1'b1;
      end
    end
  end

  // Every output is a flip-flop, inactive from reset onward
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      transport_clock     <= 1'b0;
      reset_clock_out     <= 1'b0;
      transfer_gate_clock <= 1'b0;
      white_ref_clock     <= 1'b1;
      clamp_switch_ctl    <= 1'b0;
      sample_switch_ctl   <= 1'b0;
      dark_ref_pre        <= 1'b0;
      dark_ref_post       <= 1'b0;
      line_start          <= 1'b0;
      timing_active       <= 1'b0;
    end else if (!rst_sync_n_reg) begin
      transport_clock     <= 1'b0;
      reset_clock_out     <= 1'b0;
      transfer_gate_clock <= 1'b0;
      white_ref_clock     <= 1'b1;
      clamp_switch_ctl    <= 1'b0;
      sample_switch_ctl   <= 1'b0;
      dark_ref_pre        <= 1'b0;
      dark_ref_post       <= 1'b0;
      line_start          <= 1'b0;
      timing_active       <= 1'b0;
    end else begin
      transport_clock     <= tck_next;
      reset_clock_out     <= rck_next;
      transfer_gate_clock <= xck_next;
      white_ref_clock     <= wr_next;
      clamp_switch_ctl    <= clamp_next;
      sample_switch_ctl   <= sample_next;
      dark_ref_pre        <= pre_next;
      dark_ref_post       <= post_next;
      line_start          <= start_next;
      timing_active       <= active;
    end
  end

endmodule

// File: testbench/ccd_timing_sva.sv
// Port-level timing checks for the CCD clock generator
`timescale 1ns/1ns
module ccd_timing_sva (
  input wire sys_clk,
  input wire arst_n,
  input wire transport_clock,
  input wire reset_clock_out,
  input wire transfer_gate_clock,
  input wire white_ref_clock,
  input wire clamp_switch_ctl,
  input wire sample_switch_ctl,
  input wire dark_ref_pre,
  input wire dark_ref_post,
  input wire line_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Gate outlives the transport fall, then drops while transport is still low
  sequence gate_hold_s;
    transfer_gate_clock[*8];
  endsequence
  sequence gate_low_s;
    !transfer_gate_clock && !transport_clock;
  endsequence
  rst_width_a:
    assert property ($rose(reset_clock_out) |-> reset_clock_out[*5] ##1 reset_clock_out[*5])
    else $error("reset pulse too short");
  rst_align_a:
    assert property ($rose(reset_clock_out) |-> $changed(transport_clock))
    else $error("reset pulse not on a transport edge");
  rst_each_a:
    assert property ($changed(transport_clock) |-> $rose(reset_clock_out))
    else $error("transport half without reset pulse");
  gate_rise_a:
    assert property ($rose(transfer_gate_clock) |-> $rose(transport_clock))
    else $error("gate rose away from transport rise");
  gate_fall_a:
    assert property ($fell(transport_clock) && transfer_gate_clock |->
                     gate_hold_s ##[1:600] gate_low_s)
    else $error("gate fall misplaced");
  white_gate_a:
    assert property (white_ref_clock != (transfer_gate_clock && transport_clock))
    else $error("white reference not gated by transfer");
  line_mark_a:
    assert property (line_start == $rose(transfer_gate_clock))
    else $error("line start not on gate rise");
  clamp_win_a:
    assert property (clamp_switch_ctl |-> dark_ref_pre && !dark_ref_post)
    else $error("clamp closed outside pre dark pixels");
  clamp_open_a:
    assert property ($fell(dark_ref_pre) |-> !clamp_switch_ctl && $past(clamp_switch_ctl))
    else $error("clamp not held to end of dark pixels");
  sample_win_a:
    assert property (sample_switch_ctl |-> dark_ref_post && !clamp_switch_ctl)
    else $error("sample closed outside post dark pixels");
endmodule

// File: testbench/ccd_sensor_model.sv
// Behavioural sensor model that counts data periods and charge fill
`timescale 1ns/1ns
module ccd_sensor_model (
  input  wire         sys_clk,
  input  wire         transport_clock,
  input  wire         reset_clock_out,
  input  wire         transfer_gate_clock,
  input  wire         white_ref_clock,
  output logic [15:0] pix_idx,
  output logic        fill_seen
);
  logic        rck_q = 1'b0;
  logic        xck_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  // Photosite transfer restarts the readout index
  wire         xfer_now = transfer_gate_clock && !xck_q && transport_clock;
  wire         rck_rise = reset_clock_out && !rck_q;
  initial fill_seen = 1'b0;
  // Index of the pixel now leaving, current from the edge that moves it
  assign pix_idx = xfer_now ? 16'h0000 : rck_rise ? cnt_q + 16'h0001 : cnt_q;
  always @(posedge sys_clk) begin
    rck_q <= reset_clock_out;
    xck_q <= transfer_gate_clock;
    cnt_q <= pix_idx;
    if (!white_ref_clock && transfer_gate_clock && transport_clock) begin
      fill_seen <= 1'b1;
    end
  end
endmodule

// File: testbench/linear_ccd_clock_timing_gen_tb.sv
// Self-checking bench for the CCD timing generator
`timescale 1ns/1ns
module linear_ccd_clock_timing_gen_tb;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  master_div = 8'h06;
  logic [15:0] exposure_count = 16'h0051;
  wire         transport_clock, reset_clock_out, transfer_gate_clock, white_ref_clock;
  wire         clamp_switch_ctl, sample_switch_ctl, dark_ref_pre, dark_ref_post;
  wire         line_start, timing_active, fill_seen;
  wire  [15:0] pix_idx;
  int          num_errors = 0;
  int          num_checks = 0;
  int          t = 0;
  int          cur_d = 6;
  int          tm [5];
  logic [4:0]  p = 5'h04;
  logic [31:0] lfsr_v = 32'h0000_439e;
  logic [31:0] line_q [$];
  wire  [4:0]  o = {transport_clock, transfer_gate_clock, white_ref_clock,
                    clamp_switch_ctl, sample_switch_ctl};
  wire  [6:0]  idle_v = {transport_clock, reset_clock_out, transfer_gate_clock,
                         white_ref_clock, clamp_switch_ctl, sample_switch_ctl, timing_active};

  always #2 sys_clk = ~sys_clk;

  linear_ccd_clock_timing_gen dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .run(run),
    .master_div(master_div), .exposure_count(exposure_count),
    .transport_clock(transport_clock), .reset_clock_out(reset_clock_out),
    .transfer_gate_clock(transfer_gate_clock), .white_ref_clock(white_ref_clock),
    .clamp_switch_ctl(clamp_switch_ctl), .sample_switch_ctl(sample_switch_ctl),
    .dark_ref_pre(dark_ref_pre), .dark_ref_post(dark_ref_post),
    .line_start(line_start), .timing_active(timing_active));

  ccd_sensor_model model_u (.sys_clk(sys_clk), .transport_clock(transport_clock),
    .reset_clock_out(reset_clock_out), .transfer_gate_clock(transfer_gate_clock),
    .white_ref_clock(white_ref_clock), .pix_idx(pix_idx), .fill_seen(fill_seen));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wait_ls(input int n);
    int k = 0;
    while (n > 0) begin
      @(negedge sys_clk);
      k++;
      if (line_start === 1'b1) n--;
      if (k > 30000) begin
        check("line start wait", 1, 0);
        test_done;
      end
    end
  endtask

  task automatic wait_idle;
    int k = 0;
    while (timing_active !== 1'b0) begin
      @(negedge sys_clk);
      k++;
      if (k > 5000) begin
        check("idle wait", 1, 0);
        test_done;
      end
    end
  endtask

  // Driver: one configuration per pass, notes the expected line periods
  initial begin
    int d;
    int n;
    repeat (20) @(negedge sys_clk);
    check("idle outputs", idle_v, 7'h08);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      lfsr_v = lfsr(lfsr_v);
      master_div = (i == 0) ? 8'h03 : (i == 1) ? 8'h05 : (i == 2) ? 8'h04
                 : 8'h05 + {6'h00, lfsr_v[1:0]};
      exposure_count = (i == 0) ? 16'h0050 : 16'h0051 + {13'h0000, lfsr_v[4:2]};
      d = (master_div < 8'h05) ? 6 : master_div;
      n = (exposure_count < 16'h0051) ? 81 : exposure_count;
      cur_d = d;
      run = 1'b1;
      if (i == 0) begin
        wait_ls(1);
        repeat (50) @(negedge sys_clk);
        arst_n = 1'b0;
        #1;
        check("idle outputs", idle_v, 7'h08);
        repeat (3) @(negedge sys_clk);
        arst_n = 1'b1;
      end
      repeat (2) line_q.push_back(n * 8 * d);
      wait_ls(3);
      run = 1'b0;
      wait_idle;
      check("notes left", line_q.size(), 0);
    end
    check("fill seen", fill_seen, 1'b1);
    test_done;
  end

  // Monitor: tm holds times of transport edge, line start, gate rise, white fall, clamp rise
  always @(negedge sys_clk) begin
    t++;
    if (timing_active !== 1'b1) begin
      tm = '{default: 0};
    end else begin
      if (o[4] !== p[4]) begin
        if (tm[0] > 0) check("transport half", t - tm[0], 4 * cur_d);
        tm[0] = t;
      end
      if (o[3] && !p[3]) tm[2] = t;
      if (!o[3] && p[3] && tm[2] > 0) check("gate high", t - tm[2], 6 * cur_d);
      if (!o[2] && p[2]) tm[3] = t;
      if (o[2] && !p[2] && tm[3] > 0) check("white low", t - tm[3], 4 * cur_d);
      if (o[1] && !p[1]) begin
        tm[4] = t;
        check("clamp pixel", pix_idx, 12);
      end
      if (!o[1] && p[1] && tm[4] > 0) check("clamp width", t - tm[4], 16 * cur_d);
      if (o[0] && !p[0]) check("sample pixel", pix_idx, 154);
      if (line_start === 1'b1) begin
        if (tm[1] > 0 && line_q.size() == 0) check("line note", 0, 1);
        if (tm[1] > 0 && line_q.size() > 0) check("line period", t - tm[1], line_q.pop_front());
        tm[1] = t;
      end
    end
    p = o;
  end
endmodule

bind linear_ccd_clock_timing_gen ccd_timing_sva sva_u (.sys_clk(sys_clk), .arst_n(arst_n),
  .transport_clock(transport_clock), .reset_clock_out(reset_clock_out),
  .transfer_gate_clock(transfer_gate_clock), .white_ref_clock(white_ref_clock),
  .clamp_switch_ctl(clamp_switch_ctl), .sample_switch_ctl(sample_switch_ctl),
  .dark_ref_pre(dark_ref_pre), .dark_ref_post(dark_ref_post), .line_start(line_start));
